// ==== core/rtc_pwr_pkg.sv ====
// Package with register offsets, field positions, reset values and pin state types of the power sequencer.
package rtc_pwr_pkg;
    // Register offsets on the plain register port.
    localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h31;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h32;
    localparam logic [7:0] ADDR_STATUS = 8'h30;
    localparam logic [7:0] ADDR_SEQ_STATE = 8'h40;
    // Interrupt control fields.
    localparam int INT_CTRL_SENSE_BIT = 5;
    localparam int INT_CTRL_DOWN_BIT = 6;
    localparam logic [7:0] INT_CTRL_ENABLE_MASK = 8'h3F;
    // Status fields.
    localparam int STAT_CLOCK_BIT = 0;
    localparam int STAT_ALARM_BIT = 1;
    localparam int STAT_SENSE_BIT = 2;
    localparam int STAT_TRUE_BIT = 3;
    localparam int STAT_FIRST_BIT = 4;
    // Clock control fields.
    localparam int CLK_SEL_LSB = 0;
    localparam int CLK_SEL_W = 3;
    localparam logic [2:0] CLK_SEL_PASS = 3'h0;
    // Reset values.
    localparam logic [7:0] INT_CTRL_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h10;
    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        SEQ_RUN = 2'b01,
        SEQ_DOWN = 2'b10
    } seq_state_t;
    // Output pins that travel together.
    typedef struct packed {
        logic hostReset;
        logic supplyEnable;
        logic clockOut;
        logic serialEnable;
    } pins_t;
endpackage : rtc_pwr_pkg

// ==== core/rtc_power_down_sequencer.sv ====
// Power sense and power-down sequencing logic of a serial clock with RAM.
// Overview of operation
// - Bit 5 of interrupt control enables power sensing.
// - Power-down: reset low, clock low, serial off.
// - Supply return releases reset, restores serial port.
// - Restore: clock out, supply enable, reset high.
// - Counters freeze during any serial access outside power-down.
// - Select 000 passes raw oscillator to output.
// - Clock and RAM share one access path.
// - Line inside window counts as supply failure.
// - Power sense flag survives status read.
`timescale 1ns/100ps
module rtc_power_down_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic serialActive,
    input wire logic lineInWindow,
    input wire logic system_supply_sense,
    input wire logic oscClock,
    input wire logic [7:0] dividedClocks,
    input wire logic alarmEvent,
    input wire logic periodicEvent,
    input wire logic porPinHigh,
    output logic interruptOut,
    output logic host_reset_output,
    output logic supply_enable_output,
    output logic buffered_clock_output,
    output logic serialEnable,
    output logic counterFreeze,
    output logic [7:0] accessAddr
);
    import rtc_pwr_pkg::*;

    logic [7:0] intCtrl_reg, intCtrl_next;
    logic [7:0] clkCtrl_reg, clkCtrl_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] rdata_reg, rdata_next;
    seq_state_t state_reg, state_next;
    pins_t pins_reg, pins_next;
    logic freeze_reg;
    logic irq_reg;
    logic [7:0] accAddr_reg;
    // Three-stage synchronisers for the pin inputs: sense line, supply sense, oscillator.
    logic [2:0] lineSync_reg, supSync_reg, oscSync_reg;
    logic lineLevel_reg, supLevel_reg, oscLevel_reg;
    logic supPrev_reg;

    // Stage decode and access strobes.
    // The strobes are only decoded here; acceptAccess is added at each use below, so that the refusal in power-down
    // covers the interrupt control write, the clock control write and the status read-clear alike.
    wire writeInt = regWrite && (regAddr == ADDR_INT_CTRL);
    wire writeClk = regWrite && (regAddr == ADDR_CLOCK_CTRL);
    wire readStat = regRead && (regAddr == ADDR_STATUS);
    wire supplyRise = supLevel_reg && !supPrev_reg;
    wire inDown = (state_reg == SEQ_DOWN);
    // Port disconnected during power-down: writes from the port are dropped.
    wire acceptAccess = !inDown;
    wire senseEvent = intCtrl_reg[INT_CTRL_SENSE_BIT] && lineLevel_reg;
    wire [2:0] clkSel = clkCtrl_reg[CLK_SEL_LSB +: CLK_SEL_W];
    wire selClock = (clkSel == CLK_SEL_PASS) ? oscLevel_reg : dividedClocks[clkSel];

    // Register updates; a flag set by hardware wins over the read-clear.
    // The event terms come after the read-clear terms on purpose: an event in
    // the cycle of a status read must not be lost.
    // The hardware clear of the power-down bit needs no write, since writes are refused then.
    always_comb begin
        intCtrl_next = intCtrl_reg;
        clkCtrl_next = clkCtrl_reg;
        status_next = status_reg;
        if (acceptAccess && writeInt) begin
            intCtrl_next = regWdata;
        end
        if (acceptAccess && writeClk) begin
            clkCtrl_next = regWdata;
        end
        if (acceptAccess && readStat) begin
            status_next[STAT_CLOCK_BIT] = 1'b0;
            status_next[STAT_ALARM_BIT] = 1'b0;
            status_next[STAT_TRUE_BIT] = 1'b0;
            status_next[STAT_FIRST_BIT] = !porPinHigh && status_reg[STAT_FIRST_BIT];
            // Power sense flag is kept across the read.
            status_next[STAT_SENSE_BIT] = status_reg[STAT_SENSE_BIT];
        end
        if (senseEvent) begin
            status_next[STAT_SENSE_BIT] = 1'b1;
        end
        if (alarmEvent) begin
            status_next[STAT_ALARM_BIT] = 1'b1;
        end
        if (periodicEvent) begin
            status_next[STAT_CLOCK_BIT] = 1'b1;
        end
        status_next[STAT_TRUE_BIT] = status_next[STAT_TRUE_BIT] | senseEvent | alarmEvent | periodicEvent;
        if (state_reg == SEQ_DOWN && supplyRise) begin
            intCtrl_next[INT_CTRL_DOWN_BIT] = 1'b0;
        end
    end

    // Sequencer: enter power-down on the command bit, leave only on supply return.
    // A supply edge seen while running is ignored, so the edge that follows reset is harmless.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SEQ_RUN: begin
                if (intCtrl_reg[INT_CTRL_DOWN_BIT]) begin
                    state_next = SEQ_DOWN;
                end
            end
            SEQ_DOWN: begin
                if (supplyRise) begin
                    state_next = SEQ_RUN;
                end
            end
            default: state_next = SEQ_RUN;
        endcase
    end

    // Pin levels follow the sequencer state.
    // The next state is used so that the pins move in the same edge as the state.
    always_comb begin
        if (state_next == SEQ_DOWN) begin
            pins_next = '{hostReset: 1'b0, supplyEnable: 1'b0, clockOut: 1'b0, serialEnable: 1'b0};
        end else begin
            pins_next = '{hostReset: 1'b1, supplyEnable: 1'b1, clockOut: selClock, serialEnable: 1'b1};
        end
    end

    // Read data mux; unmapped addresses read zero.
    always_comb begin
        rdata_next = 8'h00;
        if (regRead) begin
            unique case (regAddr)
                ADDR_STATUS: rdata_next = status_reg;
                ADDR_INT_CTRL: rdata_next = intCtrl_reg;
                ADDR_CLOCK_CTRL: rdata_next = clkCtrl_reg;
                ADDR_SEQ_STATE: rdata_next = {7'h00, inDown};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Input synchronisers; a change counts once stages two and three agree.
    // Only the second stage reads the first, which keeps a metastable first stage
    // away from every decision.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lineSync_reg <= 3'h0;
            supSync_reg <= 3'h0;
            oscSync_reg <= 3'h0;
            lineLevel_reg <= 1'b0;
            supLevel_reg <= 1'b0;
            oscLevel_reg <= 1'b0;
            supPrev_reg <= 1'b0;
        end else begin
            lineSync_reg <= {lineSync_reg[1:0], lineInWindow};
            supSync_reg <= {supSync_reg[1:0], system_supply_sense};
            oscSync_reg <= {oscSync_reg[1:0], oscClock};
            lineLevel_reg <= (lineSync_reg[1] == lineSync_reg[2]) ? lineSync_reg[2] : lineLevel_reg;
            supLevel_reg <= (supSync_reg[1] == supSync_reg[2]) ? supSync_reg[2] : supLevel_reg;
            oscLevel_reg <= (oscSync_reg[1] == oscSync_reg[2]) ? oscSync_reg[2] : oscLevel_reg;
            supPrev_reg <= supLevel_reg;
        end
    end

    // Register file and sequencer state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intCtrl_reg <= INT_CTRL_RESET;
            clkCtrl_reg <= CLOCK_CTRL_RESET;
            status_reg <= STATUS_RESET;
            state_reg <= SEQ_RUN;
            rdata_reg <= 8'h00;
        end else begin
            intCtrl_reg <= intCtrl_next;
            clkCtrl_reg <= clkCtrl_next;
            status_reg <= status_next;
            state_reg <= state_next;
            rdata_reg <= rdata_next;
        end
    end

    // Registered outputs; every access outside power-down, clock or RAM alike, freezes the counters.
    // The interrupt is held low from the second cycle of power-down on, where the host is kept in reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_reg <= '{hostReset: 1'b0, supplyEnable: 1'b0, clockOut: 1'b0, serialEnable: 1'b0};
            freeze_reg <= 1'b0;
            irq_reg <= 1'b0;
            accAddr_reg <= 8'h00;
        end else begin
            pins_reg <= pins_next;
            freeze_reg <= serialActive && !inDown;
            irq_reg <= |(status_next[2:0] & {intCtrl_reg[INT_CTRL_SENSE_BIT], 2'b11}) && !inDown;
            accAddr_reg <= regAddr;
        end
    end

    // Every output comes straight from a flip-flop.
    // The pin struct is unpacked here into the individual pins.
    assign regRdata = rdata_reg;
    assign interruptOut = irq_reg;
    assign host_reset_output = pins_reg.hostReset;
    assign supply_enable_output = pins_reg.supplyEnable;
    assign buffered_clock_output = pins_reg.clockOut;
    assign serialEnable = pins_reg.serialEnable;
    assign counterFreeze = freeze_reg;
    assign accessAddr = accAddr_reg;
endmodule : rtc_power_down_sequencer

// ==== verif/serial_host_model.sv ====
// Host serial engine model holding the access flag for a burst.
`timescale 1ns/100ps
module serial_host_model (
    input logic clk,
    input logic rst_n,
    input logic go,
    input logic serialEnable,
    input logic [3:0] len,
    output logic serialActive
);
    logic [3:0] left;
    // A burst starts only while the port is connected; a disconnected port refuses it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            left <= 4'h0;
        end else if (go && serialEnable) begin
            left <= len;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    assign serialActive = (left != 4'h0);
endmodule : serial_host_model

// ==== verif/rtc_pwr_sva.sv ====
// Pin checks of the power-down sequencer.
`timescale 1ns/100ps
module rtc_pwr_sva import rtc_pwr_pkg::*; (
    input logic clk, rst_n, regWrite, regRead, serialActive, lineInWindow, system_supply_sense, interruptOut,
    input logic host_reset_output, supply_enable_output, buffered_clock_output, serialEnable, counterFreeze,
    input logic [7:0] regAddr, regWdata, regRdata
);
    logic senseEn;
    wire logic ctl = regWrite && regAddr == ADDR_INT_CTRL && serialEnable;
    wire logic stRd = regRead && regAddr == ADDR_STATUS;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Sense enable as last written while the port was connected.
    always_ff @(posedge clk) senseEn <= !rst_n ? 1'b0 : ctl ? regWdata[INT_CTRL_SENSE_BIT] : senseEn;
    a_down_pins: assert property (ctl && regWdata[INT_CTRL_DOWN_BIT]
        |-> ##2 !host_reset_output && !buffered_clock_output && !serialEnable) else $error("pins up");
    a_down_hold: assert property (!serialEnable && !system_supply_sense && !$past(system_supply_sense, 6)
        && $past(rst_n) |=> !serialEnable && !host_reset_output) else $error("left down");
    a_reset_release: assert property ($rose(system_supply_sense) && !serialEnable
        |-> ##[1:10] host_reset_output && serialEnable) else $error("no release");
    a_supply_on: assert property ($rose(system_supply_sense) && !serialEnable
        |-> ##[1:10] supply_enable_output) else $error("no supply");
    a_freeze_track: assert property (serialEnable && $past(serialEnable)
        |-> counterFreeze == $past(serialActive)) else $error("freeze");
    a_sense_raise: assert property (senseEn && serialEnable && lineInWindow [*6]
        |-> ##[0:4] interruptOut) else $error("no irq");
    a_sense_kept: assert property (stRd ##1 regRdata[STAT_SENSE_BIT] && stRd
        |=> regRdata[STAT_SENSE_BIT]) else $error("flag lost");
    a_irq_quiet: assert property (!serialEnable && !$past(serialEnable) |-> !interruptOut) else $error("irq");
    c_down: cover property ($fell(serialEnable));
    c_freeze: cover property (counterFreeze);
    c_up: cover property ($rose(serialEnable));
    c_irq: cover property (interruptOut);
endmodule : rtc_pwr_sva
bind rtc_power_down_sequencer rtc_pwr_sva chk_u (.*);

// ==== verif/testbench.sv ====
// Self-checking bench of the power-down sequencer.
`timescale 1ns/100ps
module testbench;
    import rtc_pwr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, go = 1'b0, rdPend = 1'b0, oscClock = 1'b0;
    logic lineInWindow = 1'b0, system_supply_sense = 1'b1, alarmEvent = 1'b0, periodicEvent = 1'b0, porPinHigh = 1'b1;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, dividedClocks = 8'h00, regRdata;
    logic [3:0] len = 4'h1;
    logic serialActive, interruptOut, host_reset_output, supply_enable_output, buffered_clock_output, serialEnable;
    logic counterFreeze;
    logic [7:0] accessAddr;
    logic [15:0] expQ[$];
    int mismatches = 0, n_checks = 0;
    wire logic [2:0] pins = {host_reset_output, buffered_clock_output, serialEnable};
    rtc_power_down_sequencer dut_u (.*);
    serial_host_model host_u (.*);
    // Free-running 50 MHz clock.
    initial forever #10 clk = ~clk;
    task automatic check(string w, logic [7:0] s, logic [7:0] x);
        n_checks++;
        if (s !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, x, s);
        end
    endtask : check
    task automatic op(logic w, logic r, logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        {regWrite, regRead, regAddr, regWdata} <= {w, r, a, d};
    endtask : op
    task automatic rd(logic [7:0] a, logic [15:0] mv);
        expQ.push_back(mv);
        op(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic idle(int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
    endtask : idle
    task automatic waitUp(logic [1:0] sel);
        for (int i = 0; i < 300 && sel !== {serialEnable, interruptOut}; i++) idle(1);
        check("wait", {6'h00, serialEnable, interruptOut}, {6'h00, sel});
        if (mismatches != 0) report_and_stop();
    endtask : waitUp
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // Pairs each read answer with the oldest note.
    always @(posedge clk) begin
        rdPend <= regRead;
        if (rdPend) begin
            check("rdata", regRdata & expQ[0][15:8], expQ[0][7:0]);
            void'(expQ.pop_front());
        end
    end
    // Main sequence.
    initial begin
        void'($urandom(32'ha13e8277));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_STATUS, {8'hFF, STATUS_RESET});
        rd(ADDR_STATUS, 16'hFF00);
        rd(ADDR_INT_CTRL, {8'hFF, INT_CTRL_RESET});
        rd(8'h7F, 16'hFF00);
        for (int s = 0; s < 8; s++) begin
            op(1'b1, 1'b0, ADDR_CLOCK_CTRL, 8'(s));
            {oscClock, dividedClocks} <= 9'($urandom);
            idle(1);
            check("addr", accessAddr, ADDR_CLOCK_CTRL);
            idle(7);
            check("clk", {7'h00, buffered_clock_output}, {7'h00, s == 0 ? oscClock : dividedClocks[s]});
        end
        @(posedge clk);
        {len, go} <= {4'($urandom_range(8, 1)), 1'b1};
        @(posedge clk);
        go <= 1'b0;
        idle(1);
        check("freeze", {7'h00, counterFreeze}, 8'h01);
        idle(10);
        check("thaw", {7'h00, counterFreeze}, 8'h00);
        $display("clock test done");
        op(1'b1, 1'b0, ADDR_INT_CTRL, 8'h20);
        lineInWindow <= 1'b1;
        waitUp(2'b11);
        @(posedge clk);
        lineInWindow <= 1'b0;
        rd(ADDR_STATUS, 16'h0404);
        idle(40);
        rd(ADDR_STATUS, 16'h0404);
        rd(ADDR_STATUS, 16'h0404);
        $display("sense test done");
        op(1'b1, 1'b0, ADDR_INT_CTRL, 8'h40);
        system_supply_sense <= 1'b0;
        idle(3);
        check("down", {5'h00, pins}, 8'h00);
        op(1'b1, 1'b0, ADDR_CLOCK_CTRL, 8'h00);
        rd(ADDR_CLOCK_CTRL, 16'h0707);
        rd(ADDR_SEQ_STATE, 16'h0101);
        idle(50);
        check("held", {5'h00, pins}, 8'h00);
        @(posedge clk);
        system_supply_sense <= 1'b1;
        waitUp(2'b10);
        check("up", {6'h00, supply_enable_output, host_reset_output}, 8'h03);
        rd(ADDR_INT_CTRL, 16'h4000);
        idle(3);
        $display("power test done");
        report_and_stop();
    end
endmodule : testbench
